// [indirect_access_pkg.sv]
package indirect_access_pkg;

  // word and address widths of the indirect path
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 8;
  localparam int DTMF_WORDS = 13;

  // indirect word addresses of the dtmf threshold map
  localparam logic [7:0] IDX_RATIO_A      = 8'h00;
  localparam logic [7:0] IDX_RATIO_B      = 8'h01;
  localparam logic [7:0] IDX_RATIO_C      = 8'h02;
  localparam logic [7:0] IDX_RATIO_D      = 8'h03;
  localparam logic [7:0] IDX_COLUMN_RATIO = 8'h04;
  localparam logic [7:0] IDX_FWD_TWIST    = 8'h05;
  localparam logic [7:0] IDX_REV_TWIST    = 8'h06;
  localparam logic [7:0] IDX_ROW_REL      = 8'h07;
  localparam logic [7:0] IDX_COL_REL      = 8'h08;
  localparam logic [7:0] IDX_ROW_HARM     = 8'h09;
  localparam logic [7:0] IDX_COL_HARM     = 8'h0a;
  localparam logic [7:0] IDX_MIN_POWER    = 8'h0b;
  localparam logic [7:0] IDX_HOT_LIMIT    = 8'h0c;

  // loop closure hysteresis thresholds live in these indirect words elsewhere
  localparam logic [7:0] IDX_HYST_UPPER   = 8'h1c;
  localparam logic [7:0] IDX_HYST_LOWER   = 8'h2b;

  // enhancement enable bit positions
  localparam int ENH_HYST_POS     = 0;
  localparam int ENH_SQUELCH_POS  = 1;
  localparam int ENH_VLOOP_POS    = 2;
  localparam int ENH_DEBOUNCE_POS = 3;
  localparam int ENH_ZREF_POS     = 4;
  localparam int ENH_SPEEDUP_POS  = 5;
  localparam int ENH_FSK_POS      = 6;
  localparam int ENH_ILIM_POS     = 7;

  // reset values
  localparam logic [7:0]  ENH_RESET  = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [7:0]  ADDR_RESET = 8'h00;

  // timing
  localparam int CLK_HZ          = 125_000_000;
  localparam int TICK_HZ         = 16_000;
  localparam int DEBOUNCE_MS     = 60;
  localparam int TICK_CYCLES     = CLK_HZ / TICK_HZ;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;

endpackage

// [indirect_register_access.sv]
`timescale 1ns/1ps

// Summary of operation
// - A data write followed by an address write is a write request stored at the next tick.
// - An address write with no data write before it is a read that loads the data register.
// - Pending transfers are serviced only on a 16 kHz update tick.
// - The pending flag stays high from request until service and the host waits on it.
// - Each completed transfer sets a sticky done flag for the host.
// - Threshold words and loop metrics are two's-complement values.
// - Indirect words have no guaranteed value after reset, so the host programs them.
// - Thirteen 16-bit dtmf threshold words sit at indirect addresses 0 to 12.
// - Enhancement bit 4 disconnects the internal impedance reference resistor.
// - Enhancement bit 3 adds a 60 ms debounce on high to low external battery switching.
// - Enhancement bit 2 picks tip-ring voltage instead of loop current for loop closure.
// - Enhancement bit 1 enables the converter audio-band squelch.
// - Enhancement bit 0 adds hysteresis between upper and lower loop closure thresholds.
// - Enhancement bits 7 to 5 select ring-end current boost, fast fsk clocking and speedup.
module indirect_register_access
  import indirect_access_pkg::*;
#(
  parameter int TICK_CNT     = indirect_access_pkg::TICK_CYCLES,
  parameter int DEBOUNCE_CNT = indirect_access_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                                              clk,
  input  wire logic                                              rstn,
  input  wire logic                                              data_wr,
  input  wire logic [indirect_access_pkg::DATA_W-1:0]            data_wdata,
  input  wire logic                                              addr_wr,
  input  wire logic [indirect_access_pkg::ADDR_W-1:0]            addr_wdata,
  input  wire logic                                              enh_wr,
  input  wire logic [7:0]                                        enh_wdata,
  input  wire logic                                              done_clr,
  input  wire logic                                              external_battery_select,
  input  wire logic                                              battery_low_request,
  input  wire logic signed [15:0]                                loop_current,
  input  wire logic signed [15:0]                                loop_voltage,
  input  wire logic signed [15:0]                                hyst_upper_threshold,
  input  wire logic signed [15:0]                                hyst_lower_threshold,
  output logic [indirect_access_pkg::DATA_W-1:0]                 indirect_data_holding,
  output logic [indirect_access_pkg::ADDR_W-1:0]                 indirect_address_holding,
  output logic                                                   indirect_access_pending,
  output logic                                                   indirect_done_irq,
  output logic [7:0]                                             enhancement_enable,
  output logic [indirect_access_pkg::DTMF_WORDS*16-1:0]          dtmf_thresholds,
  output logic                                                   impedance_ref_disable,
  output logic                                                   battery_switch_debounce,
  output logic                                                   voltage_loop_closure,
  output logic                                                   converter_squelch,
  output logic                                                   loop_closure_hysteresis,
  output logic                                                   ring_end_current_boost,
  output logic                                                   fsk_fast_clocking,
  output logic                                                   converter_speedup,
  output logic                                                   low_battery_supply,
  output logic                                                   high_battery_supply,
  output logic                                                   loop_closed
);
  import indirect_access_pkg::*;

  localparam int TICK_W = $clog2(TICK_CNT + 1);
  localparam int DEB_W  = $clog2(DEBOUNCE_CNT + 1);

  typedef logic [DTMF_WORDS-1:0][DATA_W-1:0] word_map_t;

  typedef struct packed {
    word_map_t         mem;
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] addr;
    logic              data_armed;
    logic              pending;
    logic              pend_write;
    logic              done;
    logic [7:0]        enh;
    logic [TICK_W-1:0] tick_cnt;
    logic [DEB_W-1:0]  deb_cnt;
    logic              low_bat;
    logic              closed;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic   tick;
  logic   svc;
  logic   mapped;
  logic signed [15:0] metric;
  logic [DATA_W-1:0]  word_at_addr;

  // indirect read; unmapped addresses read as zero
  function automatic logic [DATA_W-1:0] read_word(input word_map_t m, input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w;
    w = '0;
    if (a < ADDR_W'(DTMF_WORDS)) begin
      w = m[a[3:0]];
    end
    return w;
  endfunction

  assign tick = (s_r.tick_cnt == TICK_W'(TICK_CNT - 1));
  assign svc          = tick && s_r.pending;
  assign mapped       = (s_r.addr < ADDR_W'(DTMF_WORDS));
  assign word_at_addr = read_word(s_r.mem, s_r.addr);
  assign metric = s_r.enh[ENH_VLOOP_POS] ? loop_voltage : loop_current;

  // next-state of the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + TICK_W'(1);
    // host data write only arms a write; it never touches indirect memory itself
    if (data_wr) begin
      s_nxt.data       = data_wdata;
      s_nxt.data_armed = 1'h1;
    end
    // address writes while pending are ignored, host must wait
    if (addr_wr && !s_r.pending) begin
      s_nxt.addr       = addr_wdata;
      s_nxt.pending    = 1'h1;
      // armed data makes a write request
      s_nxt.pend_write = s_r.data_armed || data_wr;
      s_nxt.data_armed = 1'h0;
    end
    if (svc) begin
      if (s_r.pend_write) begin
        // only addresses 0 to 12 hold words
        if (mapped) begin
          s_nxt.mem[s_r.addr[3:0]] = s_r.data;
        end
      end else begin
        // read loads the data holding register; beats a same-cycle host write
        s_nxt.data = word_at_addr;
      end
      // pending drops and done rises together
      s_nxt.pending = 1'h0;
    end
    // sticky done; a set in the clear cycle wins
    if (done_clr) begin
      s_nxt.done = 1'h0;
    end
    if (svc) begin
      s_nxt.done = 1'h1;
    end
    if (enh_wr) begin
      s_nxt.enh = enh_wdata;
    end
    // debounce only high to low with external battery selected
    s_nxt.deb_cnt = '0;
    if (!battery_low_request) begin
      s_nxt.low_bat = 1'h0;
    end else if (!s_r.low_bat) begin
      if (!(s_r.enh[ENH_DEBOUNCE_POS] && external_battery_select)) begin
        s_nxt.low_bat = 1'h1;
      end else if (s_r.deb_cnt == DEB_W'(DEBOUNCE_CNT - 1)) begin
        s_nxt.low_bat = 1'h1;
      end else begin
        s_nxt.deb_cnt = s_r.deb_cnt + DEB_W'(1);
      end
    end
    // hysteresis band versus plain upper threshold
    if (s_r.enh[ENH_HYST_POS]) begin
      s_nxt.closed = s_r.closed ? (metric > hyst_lower_threshold) : (metric > hyst_upper_threshold);
    end else begin
      s_nxt.closed = (metric > hyst_upper_threshold);
    end
  end

  // words cleared here only so simulation starts clean; host must still program them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r            <= '0;
      s_r.data       <= DATA_RESET;
      s_r.addr       <= ADDR_RESET;
      s_r.enh        <= ENH_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // register outputs
  assign indirect_data_holding    = s_r.data;
  assign indirect_address_holding = s_r.addr;
  assign indirect_access_pending  = s_r.pending;
  assign indirect_done_irq        = s_r.done;
  assign enhancement_enable       = s_r.enh;
  assign dtmf_thresholds          = s_r.mem;
  assign impedance_ref_disable    = s_r.enh[ENH_ZREF_POS];
  assign battery_switch_debounce  = s_r.enh[ENH_DEBOUNCE_POS];
  assign voltage_loop_closure     = s_r.enh[ENH_VLOOP_POS];
  assign converter_squelch        = s_r.enh[ENH_SQUELCH_POS];
  assign loop_closure_hysteresis  = s_r.enh[ENH_HYST_POS];
  assign ring_end_current_boost   = s_r.enh[ENH_ILIM_POS];
  assign fsk_fast_clocking        = s_r.enh[ENH_FSK_POS];
  assign converter_speedup        = s_r.enh[ENH_SPEEDUP_POS];
  assign low_battery_supply       = s_r.low_bat;
  assign high_battery_supply      = !s_r.low_bat;
  assign loop_closed              = s_r.closed;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_request;
    addr_wr && !indirect_access_pending;
  endsequence

  sequence s_service;
    tick && indirect_access_pending;
  endsequence

  a_request_kind: assert property (s_request |=> indirect_access_pending &&
      (s_r.pend_write == $past(s_r.data_armed || data_wr)))
    else $error("request kind or pending wrong");

  a_write_store: assert property (s_service ##0 (s_r.pend_write && mapped)
      |=> word_at_addr == $past(s_r.data))
    else $error("indirect write not stored");

  a_read_load: assert property (s_service ##0 !s_r.pend_write
      |=> indirect_data_holding == $past(word_at_addr))
    else $error("indirect read not loaded");

  a_tick_only: assert property ($fell(indirect_access_pending) |-> $past(tick))
    else $error("service off tick");

  a_tick_gap: assert property (tick |=> (!tick)[*8])
    else $error("ticks too close");

  a_pending_hold: assert property (indirect_access_pending && !tick
      |=> indirect_access_pending)
    else $error("pending dropped early");

  a_done_raise: assert property (s_service |=> indirect_done_irq && !indirect_access_pending)
    else $error("done and pending not together");

  a_done_sticky: assert property (indirect_done_irq && !done_clr |=> indirect_done_irq)
    else $error("done flag lost");

  a_zref_bit: assert property (enh_wr |=> impedance_ref_disable == $past(enh_wdata[4]))
    else $error("reference disable bit wrong");

  a_bat_rise: assert property (!battery_low_request |=> !low_battery_supply)
    else $error("return to high battery delayed");

  a_squelch_bit: assert property (enh_wr |=> converter_squelch == $past(enh_wdata[1]))
    else $error("squelch bit wrong");

  a_loop_plain: assert property (!loop_closure_hysteresis && !enh_wr
      |=> loop_closed == $past(metric > hyst_upper_threshold))
    else $error("loop closure decision wrong");

  a_mem_quiet: assert property (!svc |=> $stable(s_r.mem))
    else $error("indirect word changed off service");

  a_unmapped_write: assert property (s_service ##0 (s_r.pend_write && !mapped)
      |=> $stable(s_r.mem))
    else $error("unmapped write touched a word");

  a_unmapped_read: assert property (s_service ##0 (!s_r.pend_write && !mapped)
      |=> indirect_data_holding == '0)
    else $error("unmapped read not zero");

  a_data_kept: assert property (!svc && !data_wr |=> $stable(indirect_data_holding))
    else $error("data holding changed unasked");

  a_done_clear: assert property (done_clr && !svc |=> !indirect_done_irq)
    else $error("done flag not cleared");

  a_debounce_wait: assert property ($rose(low_battery_supply)
      && $past(battery_switch_debounce && external_battery_select)
      |-> $past(s_r.deb_cnt) == DEB_W'(DEBOUNCE_CNT - 1))
    else $error("low battery before debounce ran out");

  a_bat_direct: assert property (battery_low_request
      && !(battery_switch_debounce && external_battery_select) |=> low_battery_supply)
    else $error("undebounced switch to low battery late");

  a_hyst_rise: assert property (loop_closure_hysteresis && !loop_closed
      |=> loop_closed == $past(metric > hyst_upper_threshold))
    else $error("closure rise off upper threshold");

  a_hyst_keep: assert property (loop_closure_hysteresis && loop_closed
      && (metric > hyst_lower_threshold) |=> loop_closed)
    else $error("closure lost above lower threshold");

  a_hyst_release: assert property (loop_closure_hysteresis && loop_closed
      && !(metric > hyst_lower_threshold) |=> !loop_closed)
    else $error("closure kept below lower threshold");

  a_upper_bits: assert property (enh_wr |=>
      {ring_end_current_boost, fsk_fast_clocking, converter_speedup}
      == $past(enh_wdata[7:5]))
    else $error("upper enhancement selects wrong");

  a_vloop_bit: assert property (enh_wr
      |=> voltage_loop_closure == $past(enh_wdata[2]))
    else $error("loop closure select bit wrong");

  a_debounce_bit: assert property (enh_wr
      |=> battery_switch_debounce == $past(enh_wdata[3]))
    else $error("debounce enable bit wrong");

  a_hyst_bit: assert property (enh_wr
      |=> loop_closure_hysteresis == $past(enh_wdata[0]))
    else $error("hysteresis enable bit wrong");

endmodule // indirect_register_access

// [host_model.sv]
`timescale 1ns/1ps
// host side of the direct register map: data word, then address
module host_model (
  input  wire logic                                clk,
  input  wire logic                                pend,
  output logic                                     data_wr,
  output logic [indirect_access_pkg::DATA_W-1:0]   data_wdata,
  output logic                                     addr_wr,
  output logic [indirect_access_pkg::ADDR_W-1:0]   addr_wdata
);
  import indirect_access_pkg::*;

  // strobes idle low from time zero
  initial begin
    data_wr = 1'b0;
    data_wdata = 16'h0000;
    addr_wr = 1'b0;
    addr_wdata = 8'h00;
  end

  // called at a falling edge; released buses show the inverse so stale data never looks valid
  // one request at a time, words programmed before use
  task automatic req(input logic wr, input logic [15:0] d, input logic [7:0] a);
    int n;
    n = 0;
    while (pend !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (wr) begin
      data_wr = 1'b1;
      data_wdata = d;
      @(negedge clk);
      data_wr = 1'b0;
      data_wdata = ~d;
    end
    addr_wr = 1'b1;
    addr_wdata = a;
    @(negedge clk);
    addr_wr = 1'b0;
    addr_wdata = ~a;
  endtask
endmodule // host_model

// [indirect_register_access_tb_top.sv]
`timescale 1ns/1ps
module indirect_register_access_tb_top;
  import indirect_access_pkg::*;
  // short tick keeps the run small
  localparam int TK = 16;
  logic               clk = 1'b0;
  logic               rstn = 1'b0;
  logic               data_wr, addr_wr, enh_wr, done_clr, ext_sel, low_req;
  logic        [15:0] data_wdata, data_h;
  logic        [7:0]  addr_wdata, enh_wdata, enh, addr_h;
  logic signed [15:0] cur, volt, up, lo;
  logic        [207:0] dtmf;
  logic               pend, done, zref, dbnc, vlc, sq, hy, ilim, fsk, su, lowb, highb, closed;
  int                 failures = 0;
  int                 samples_checked = 0;
  int                 cyc = 0;
  int                 t0 = -1;

  indirect_register_access #(.TICK_CNT(TK), .DEBOUNCE_CNT(20)) i_indirect_register_access (
    .clk, .rstn, .data_wr, .data_wdata, .addr_wr, .addr_wdata, .enh_wr, .enh_wdata, .done_clr,
    .external_battery_select(ext_sel), .battery_low_request(low_req), .loop_current(cur),
    .loop_voltage(volt), .hyst_upper_threshold(up), .hyst_lower_threshold(lo),
    .indirect_data_holding(data_h), .indirect_address_holding(addr_h),
    .indirect_access_pending(pend), .indirect_done_irq(done), .enhancement_enable(enh),
    .dtmf_thresholds(dtmf), .impedance_ref_disable(zref), .battery_switch_debounce(dbnc),
    .voltage_loop_closure(vlc), .converter_squelch(sq), .loop_closure_hysteresis(hy),
    .ring_end_current_boost(ilim), .fsk_fast_clocking(fsk), .converter_speedup(su),
    .low_battery_supply(lowb), .high_battery_supply(highb), .loop_closed(closed));

  host_model i_host_model (.clk, .pend, .data_wr, .data_wdata, .addr_wr, .addr_wdata);

  // 125 mhz clock and a free cycle count for the tick phase
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // services must all land on one tick phase
  task automatic wait_idle();
    int n;
    n = 0;
    check("pending set", 16'(pend), 16'h0001);
    while (pend !== 1'b0 && n < 2 * TK) begin
      @(negedge clk);
      n++;
    end
    if (t0 < 0) t0 = cyc;
    check("tick phase", 16'((cyc - t0) % TK), 16'h0000);
    check("done with idle", 16'({pend, done}), 16'h0001);
    check("wait bound", 16'(n > TK + 1), 16'h0000);
  endtask

  task automatic clr_done();
    done_clr = 1'b1;
    @(negedge clk);
    done_clr = 1'b0;
    check("done cleared", 16'(done), 16'h0000);
  endtask

  task automatic set_enh(input logic [7:0] v);
    enh_wr = 1'b1;
    enh_wdata = v;
    @(negedge clk);
    enh_wr = 1'b0;
    enh_wdata = ~v;
    // idle edge so back-to-back calls never re-raise the strobe in one step
    @(negedge clk);
    check("enh readback", 16'(enh), 16'(v));
  endtask

  task automatic t_xfer();
    i_host_model.req(1'b1, 16'h8123, 8'h03);
    wait_idle();
    check("word 3", dtmf[63:48], 16'h8123);
    clr_done();
    i_host_model.req(1'b1, 16'h0abc, 8'h0c);
    wait_idle();
    check("word 12", dtmf[207:192], 16'h0abc);
    clr_done();
    i_host_model.req(1'b0, 16'h0000, 8'h03);
    wait_idle();
    check("read back", data_h, 16'h8123);
    clr_done();
    // address 13 holds no word: write dropped, read gives zero
    i_host_model.req(1'b1, 16'h5555, 8'h0d);
    wait_idle();
    check("word 12 kept", dtmf[207:192], 16'h0abc);
    clr_done();
    i_host_model.req(1'b0, 16'h0000, 8'h0d);
    wait_idle();
    check("address held", 16'(addr_h), 16'h000d);
    check("unmapped read", data_h, 16'h0000);
    clr_done();
    $display("test transfers done");
  endtask

  task automatic t_enh();
    logic [7:0] pins;
    for (int i = 0; i < 8; i++) begin
      set_enh(8'h01 << i);
      pins = {ilim, fsk, su, zref, dbnc, vlc, sq, hy};
      check("enh bits", 16'(pins), 16'h0001 << i);
    end
    $display("test enhancement done");
  endtask

  // thresholds straddle zero so signed compares matter
  task automatic t_loop();
    up = 16'h0064;
    lo = 16'hffce;
    cur = 16'h00c8;
    set_enh(8'h00);
    repeat (2) @(negedge clk);
    check("closed by current", 16'(closed), 16'h0001);
    set_enh(8'h04);
    repeat (2) @(negedge clk);
    check("open by voltage", 16'(closed), 16'h0000);
    set_enh(8'h01);
    repeat (2) @(negedge clk);
    check("hysteresis rise", 16'(closed), 16'h0001);
    // below upper but above a negative lower: only a signed compare keeps it closed
    cur = 16'h000a;
    repeat (2) @(negedge clk);
    check("hysteresis holds", 16'(closed), 16'h0001);
    cur = 16'hff9c;
    repeat (2) @(negedge clk);
    check("hysteresis release", 16'(closed), 16'h0000);
    $display("test loop closure done");
  endtask

  task automatic t_bat();
    ext_sel = 1'b1;
    set_enh(8'h08);
    low_req = 1'b1;
    repeat (10) @(negedge clk);
    check("debounce holds", 16'(lowb), 16'h0000);
    repeat (15) @(negedge clk);
    check("debounced switch", 16'({lowb, highb}), 16'h0002);
    low_req = 1'b0;
    set_enh(8'h00);
    low_req = 1'b1;
    repeat (2) @(negedge clk);
    check("no debounce", 16'(lowb), 16'h0001);
    // debounce only applies with the external battery option
    low_req = 1'b0;
    ext_sel = 1'b0;
    set_enh(8'h08);
    low_req = 1'b1;
    repeat (2) @(negedge clk);
    check("internal battery fast", 16'(lowb), 16'h0001);
    $display("test battery done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence, inputs moved on falling edges
  initial begin
    done_clr = 1'b0;
    enh_wr = 1'b0;
    enh_wdata = 8'h00;
    ext_sel = 1'b0;
    low_req = 1'b0;
    cur = 16'h0000;
    volt = 16'h0000;
    up = 16'h0000;
    lo = 16'h0000;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    check("reset flags", 16'({pend, done, lowb, highb}), 16'h0001);
    t_xfer();
    t_enh();
    t_loop();
    t_bat();
    stop_test();
  end

  // whole run is under two hundred cycles; this cuts a hang
  initial begin
    #160000;
    failures++;
    stop_test();
  end
endmodule // indirect_register_access_tb_top
